// ---- core/rml_axis.v ----
`timescale 1ns/1ps
`default_nettype none
`include "rml_consts.vh"
module rml_axis #(
    parameter [23:0] RESET_WAIT_CYC = `RML_RESET_WAIT_CYC
) (
    input  wire        CLK_SYS_I,        // 50 MHz clock
    input  wire        RESET_N_I,        // async reset, low
    input  wire        CMD_VALID_I,      // command strobe
    input  wire [3:0]  CMD_CODE_I,       // command code
    input  wire [1:0]  CMD_OPT_I,        // capture option / monitor mode
    input  wire [31:0] CMD_LIMIT_I,      // monitor tolerance, periods
    input  wire [1:0]  AXIS_IF_I,        // configured interface kind
    input  wire        POLLED_MODE_I,    // polled operating mode
    input  wire        POWER_FAULT_I,    // encoder supply fault
    input  wire [31:0] PERIOD_CNT_I,     // axis period counter
    input  wire        REF_PULSE_I,      // reference pulse event
    input  wire        ERR_AMPL_I,       // amplitude error event
    input  wire        ERR_FREQ_I,       // frequency error event
    input  wire        ERR_CRC_I,        // transfer crc error event
    input  wire        ERR_ENC_MSG_I,    // encoder error message event
    input  wire        CODED_OK_I,       // coded ref value valid event
    input  wire        CODED_ERR_I,      // coded ref calc error event
    input  wire        ENC_FRAME_DONE_I, // encoder frame finished
    output reg         CMD_DONE_O,       // command completion pulse
    output reg  [2:0]  CMD_ERR_O,        // return code
    output reg         CMD_BUSY_O,       // command in progress
    output reg  [9:0]  STATUS_O,         // axis status word
    output reg  [31:0] REF_POS1_O,       // first reference position
    output reg  [31:0] REF_POS2_O,       // second reference position
    output reg         RUN_ACTIVE_O,     // reference run active
    output reg         MON_EN_O,         // reference monitoring on
    output reg  [31:0] MON_LIMIT_O,      // monitoring tolerance
    output reg         ENC_RESET_REQ_O,  // send reset frame pulse
    output reg         ENC_POS_REQ_O,    // send position frame pulse
    output reg         ENC_REV_O         // revision of requested frame
);
    // -----------------------------------------------------------
    // command sequencer states
    // -----------------------------------------------------------
    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_WAIT  = 2'h1;
    localparam [1:0] S_FRAME = 2'h2;

    reg [1:0]  state_r;
    reg        flg_ref1_r;
    reg        flg_ref2_r;
    reg        flg_coded_ok_r;
    reg        flg_coded_err_r;
    reg        flg_ampl_r;
    reg        flg_freq_r;
    reg        flg_crc_r;
    reg        flg_msg_r;
    reg        flg_inval_r;
    reg        run_two_r;
    reg        wait_start_r;
    wire       wait_done;

    // -----------------------------------------------------------
    // command decode
    // -----------------------------------------------------------
    wire idle     = (state_r == S_IDLE);
    wire cmd      = CMD_VALID_I & idle;
    wire is_incr  = (AXIS_IF_I == `RML_IF_INCR) | (AXIS_IF_I == `RML_IF_CODED);
    wire is_coded = (AXIS_IF_I == `RML_IF_CODED);
    wire is_ser   = (AXIS_IF_I == `RML_IF_SERIAL);
    wire unconf   = (AXIS_IF_I == `RML_IF_NONE);
    wire opt_ok   = (CMD_OPT_I == `RML_CAP_ONE) | (CMD_OPT_I == `RML_CAP_TWO);

    reg [2:0] err_nxt;
    always @*
    begin
        err_nxt = `RML_ERR_OK;
        case (CMD_CODE_I)
            `RML_CMD_ACK_SIG:
                if (unconf) err_nxt = `RML_ERR_UNCONF;
            `RML_CMD_CLR_SER:
                if (unconf) err_nxt = `RML_ERR_UNCONF;
                else if (!is_ser) err_nxt = `RML_ERR_IFACE;
                else if (POWER_FAULT_I) err_nxt = `RML_ERR_POWER;
                else if (!POLLED_MODE_I) err_nxt = `RML_ERR_MODE;
            `RML_CMD_CLR_LAT:
                if (unconf) err_nxt = `RML_ERR_UNCONF;
                else if (!is_incr) err_nxt = `RML_ERR_IFACE;
            `RML_CMD_CLR_STAT:
                if (unconf) err_nxt = `RML_ERR_UNCONF;
                else if (!is_coded) err_nxt = `RML_ERR_IFACE;
            `RML_CMD_START:
                if (unconf) err_nxt = `RML_ERR_UNCONF;
                else if (!is_incr) err_nxt = `RML_ERR_IFACE;
                else if (!opt_ok) err_nxt = `RML_ERR_PARAM;
            `RML_CMD_STOP:
                if (unconf) err_nxt = `RML_ERR_UNCONF;
                else if (!is_incr) err_nxt = `RML_ERR_IFACE;
            `RML_CMD_QUERY:
                err_nxt = `RML_ERR_OK;
            `RML_CMD_MONITOR:
                if (!is_incr) err_nxt = `RML_ERR_IFACE;
                else if (CMD_OPT_I[1]) err_nxt = `RML_ERR_PARAM;
            `RML_CMD_LEGACY:
                if (unconf) err_nxt = `RML_ERR_UNCONF;
                else if (!is_ser) err_nxt = `RML_ERR_IFACE;
                else if (POWER_FAULT_I) err_nxt = `RML_ERR_POWER;
                else if (!POLLED_MODE_I) err_nxt = `RML_ERR_MODE;
            default:
                err_nxt = `RML_ERR_PARAM;
        endcase
    end

    wire ok      = cmd & (err_nxt == `RML_ERR_OK);
    wire do_ack  = ok & (CMD_CODE_I == `RML_CMD_ACK_SIG);
    wire do_ser  = ok & (CMD_CODE_I == `RML_CMD_CLR_SER);
    wire do_lat  = ok & (CMD_CODE_I == `RML_CMD_CLR_LAT);
    wire do_stat = ok & (CMD_CODE_I == `RML_CMD_CLR_STAT);
    wire do_strt = ok & (CMD_CODE_I == `RML_CMD_START);
    wire do_stop = ok & (CMD_CODE_I == `RML_CMD_STOP);
    wire do_mon  = ok & (CMD_CODE_I == `RML_CMD_MONITOR);
    wire do_leg  = ok & (CMD_CODE_I == `RML_CMD_LEGACY);

    // -----------------------------------------------------------
    // reference capture
    // -----------------------------------------------------------
    // pulse in the start cycle is ignored: capture needs the next mark
    wire need1 = RUN_ACTIVE_O & ~flg_ref1_r;
    wire cap1  = REF_PULSE_I & need1 & ~do_strt & ~do_stop;
    wire cap2  = REF_PULSE_I & RUN_ACTIVE_O & run_two_r & flg_ref1_r
                 & ~flg_ref2_r & ~do_strt & ~do_stop;

    always @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            REF_POS1_O   <= 32'h00000000;
            REF_POS2_O   <= 32'h00000000;
            RUN_ACTIVE_O <= 1'b0;
            run_two_r    <= 1'b0;
            flg_ref1_r   <= 1'b0;
            flg_ref2_r   <= 1'b0;
            flg_inval_r  <= 1'b0;
        end
        else
        begin
            if (cap1)
                REF_POS1_O <= PERIOD_CNT_I;
            if (cap2)
                REF_POS2_O <= PERIOD_CNT_I;
            if (do_strt)
            begin
                // restart before completion marks the old values invalid
                if (RUN_ACTIVE_O)
                    flg_inval_r <= 1'b1;
                flg_ref1_r   <= 1'b0;
                flg_ref2_r   <= 1'b0;
                run_two_r    <= (CMD_OPT_I == `RML_CAP_TWO);
                RUN_ACTIVE_O <= 1'b1;
            end
            else if (do_stop)
                RUN_ACTIVE_O <= 1'b0;
            else
            begin
                if (cap1)
                    flg_ref1_r <= 1'b1;
                else if (do_lat | do_stat)
                    flg_ref1_r <= 1'b0;
                if (cap2)
                    flg_ref2_r <= 1'b1;
                else if (do_lat | do_stat)
                    flg_ref2_r <= 1'b0;
                if ((cap1 & ~run_two_r) | cap2)
                    RUN_ACTIVE_O <= 1'b0;
                if (cap1 | do_lat | do_stat)
                    flg_inval_r <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // sticky error and coded flags, set wins over clear
    // -----------------------------------------------------------
    always @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            flg_ampl_r      <= 1'b0;
            flg_freq_r      <= 1'b0;
            flg_crc_r       <= 1'b0;
            flg_msg_r       <= 1'b0;
            flg_coded_ok_r  <= 1'b0;
            flg_coded_err_r <= 1'b0;
        end
        else
        begin
            flg_ampl_r      <= ERR_AMPL_I | (flg_ampl_r & ~(do_ack & is_incr));
            flg_freq_r      <= ERR_FREQ_I | (flg_freq_r & ~(do_ack & is_incr));
            flg_crc_r       <= ERR_CRC_I | (flg_crc_r & ~((do_ack & is_ser) | do_ser));
            flg_msg_r       <= ERR_ENC_MSG_I | (flg_msg_r & ~((do_ack & is_ser) | do_ser));
            flg_coded_ok_r  <= CODED_OK_I | (flg_coded_ok_r & ~do_stat);
            flg_coded_err_r <= CODED_ERR_I | (flg_coded_err_r & ~do_stat);
        end
    end

    // -----------------------------------------------------------
    // monitoring setup
    // -----------------------------------------------------------
    always @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            MON_EN_O    <= 1'b0;
            MON_LIMIT_O <= 32'h00000000;
        end
        else if (do_mon)
        begin
            MON_EN_O    <= CMD_OPT_I[0];
            MON_LIMIT_O <= CMD_LIMIT_I;
        end
    end

    // -----------------------------------------------------------
    // command sequencer and answers
    // -----------------------------------------------------------
    rml_wait_timer #(
        .WAIT_CYC (RESET_WAIT_CYC)
    ) u_wait (
        .clk_i     (CLK_SYS_I),
        .reset_n_i (RESET_N_I),
        .start_i   (wait_start_r),
        .busy_o    (),
        .done_o    (wait_done)
    );

    always @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state_r         <= S_IDLE;
            wait_start_r    <= 1'b0;
            CMD_DONE_O      <= 1'b0;
            CMD_ERR_O       <= `RML_ERR_OK;
            CMD_BUSY_O      <= 1'b0;
            ENC_RESET_REQ_O <= 1'b0;
            ENC_POS_REQ_O   <= 1'b0;
            ENC_REV_O       <= `RML_REV_OLD;
        end
        else
        begin
            CMD_DONE_O      <= 1'b0;
            wait_start_r    <= 1'b0;
            ENC_RESET_REQ_O <= 1'b0;
            ENC_POS_REQ_O   <= 1'b0;
            case (state_r)
                S_IDLE:
                    if (CMD_VALID_I)
                    begin
                        CMD_ERR_O <= err_nxt;
                        if (do_ser)
                        begin
                            ENC_RESET_REQ_O <= 1'b1;
                            ENC_REV_O       <= `RML_REV_OLD;
                            wait_start_r    <= 1'b1;
                            CMD_BUSY_O      <= 1'b1;
                            state_r         <= S_WAIT;
                        end
                        else if (do_leg)
                        begin
                            ENC_POS_REQ_O <= 1'b1;
                            ENC_REV_O     <= `RML_REV_OLD;
                            CMD_BUSY_O    <= 1'b1;
                            state_r       <= S_FRAME;
                        end
                        else
                            CMD_DONE_O <= 1'b1;
                    end
                S_WAIT:
                    // settle time after encoder reset before completing
                    if (wait_done)
                    begin
                        CMD_DONE_O <= 1'b1;
                        CMD_BUSY_O <= 1'b0;
                        state_r    <= S_IDLE;
                    end
                S_FRAME:
                    if (ENC_FRAME_DONE_I)
                    begin
                        CMD_DONE_O <= 1'b1;
                        CMD_BUSY_O <= 1'b0;
                        state_r    <= S_IDLE;
                    end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------
    // status word
    // -----------------------------------------------------------
    always @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            STATUS_O <= 10'h000;
        else
        begin
            STATUS_O[`RML_ST_REF1]      <= flg_ref1_r;
            STATUS_O[`RML_ST_REF2]      <= flg_ref2_r;
            STATUS_O[`RML_ST_CODED_OK]  <= flg_coded_ok_r;
            STATUS_O[`RML_ST_CODED_ERR] <= flg_coded_err_r;
            STATUS_O[`RML_ST_AMPL]      <= flg_ampl_r;
            STATUS_O[`RML_ST_FREQ]      <= flg_freq_r;
            STATUS_O[`RML_ST_CRC]       <= flg_crc_r;
            STATUS_O[`RML_ST_ENC_MSG]   <= flg_msg_r;
            STATUS_O[`RML_ST_REF_INVAL] <= flg_inval_r;
            STATUS_O[`RML_ST_RUN]       <= RUN_ACTIVE_O;
        end
    end
endmodule
`default_nettype wire

// ---- common/rml_consts.vh ----
`ifndef RML_CONSTS_VH
`define RML_CONSTS_VH

// axis interface kinds
`define RML_IF_NONE      2'h0
`define RML_IF_INCR      2'h1
`define RML_IF_CODED     2'h2
`define RML_IF_SERIAL    2'h3

// command codes
`define RML_CMD_NOP      4'h0
`define RML_CMD_ACK_SIG  4'h1
`define RML_CMD_CLR_SER  4'h2
`define RML_CMD_CLR_LAT  4'h3
`define RML_CMD_CLR_STAT 4'h4
`define RML_CMD_START    4'h5
`define RML_CMD_STOP     4'h6
`define RML_CMD_QUERY    4'h7
`define RML_CMD_MONITOR  4'h8
`define RML_CMD_LEGACY   4'h9

// capture options
`define RML_CAP_ONE      2'h1
`define RML_CAP_TWO      2'h2

// return codes
`define RML_ERR_OK       3'h0
`define RML_ERR_IFACE    3'h1
`define RML_ERR_UNCONF   3'h2
`define RML_ERR_POWER    3'h3
`define RML_ERR_PARAM    3'h4
`define RML_ERR_MODE     3'h5

// status word bit positions
`define RML_ST_REF1      0
`define RML_ST_REF2      1
`define RML_ST_CODED_OK  2
`define RML_ST_CODED_ERR 3
`define RML_ST_AMPL      4
`define RML_ST_FREQ      5
`define RML_ST_CRC       6
`define RML_ST_ENC_MSG   7
`define RML_ST_REF_INVAL 8
`define RML_ST_RUN       9

// protocol revisions
`define RML_REV_OLD      1'b0

// timing
`define RML_CLK_HZ       50000000
`define RML_RESET_WAIT_MS 50
// 50 ms at 50 MHz, sized to the wait counter
`define RML_RESET_WAIT_CYC 24'h2625A0

`endif

// ---- core/rml_wait_timer.v ----
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------
// one-shot wait counter
// -----------------------------------------------------------
module rml_wait_timer #(
    parameter [23:0] WAIT_CYC = 24'h2625A0
) (
    input  wire        clk_i,    // system clock
    input  wire        reset_n_i, // async reset, low
    input  wire        start_i,  // start pulse
    output reg         busy_o,   // counting
    output reg         done_o    // one-cycle end pulse
);
    reg [23:0] cnt_r;

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_r  <= 24'h000000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                cnt_r  <= WAIT_CYC - 24'h000001;
                busy_o <= 1'b1;
            end
            else if (busy_o)
            begin
                if (cnt_r == 24'h000000)
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                else
                begin
                    cnt_r <= cnt_r - 24'h000001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/rml_axis_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rml_consts.vh"
module rml_axis_props #(
    parameter [23:0] RESET_WAIT_CYC = 24'h000014
) (
    input wire        CLK_SYS_I,       // clock
    input wire        RESET_N_I,       // reset
    input wire        CMD_VALID_I,     // strobe
    input wire [3:0]  CMD_CODE_I,      // code
    input wire [1:0]  CMD_OPT_I,       // option
    input wire [1:0]  AXIS_IF_I,       // axis kind
    input wire        POLLED_MODE_I,   // polled
    input wire        POWER_FAULT_I,   // supply
    input wire [31:0] PERIOD_CNT_I,    // counter
    input wire        REF_PULSE_I,     // mark
    input wire        CMD_DONE_O,      // done
    input wire [2:0]  CMD_ERR_O,       // code
    input wire        CMD_BUSY_O,      // busy
    input wire [9:0]  STATUS_O,        // status
    input wire [31:0] REF_POS1_O,      // pos 1
    input wire [31:0] REF_POS2_O,      // pos 2
    input wire        RUN_ACTIVE_O,    // run
    input wire        ENC_RESET_REQ_O, // reset frame
    input wire        ENC_POS_REQ_O,   // pos frame
    input wire        ENC_REV_O        // revision
);
// ----
// decoded requests
// ----
localparam int WD = RESET_WAIT_CYC + 2;
wire tk  = CMD_VALID_I && !CMD_BUSY_O;
wire non = AXIS_IF_I == `RML_IF_NONE;
wire ser = AXIS_IF_I == `RML_IF_SERIAL;
wire cs  = tk && CMD_CODE_I == `RML_CMD_CLR_SER;
wire ack = tk && CMD_CODE_I == `RML_CMD_ACK_SIG && !non;
default clocking cb @(posedge CLK_SYS_I);
endclocking
default disable iff (!RESET_N_I);
// ----
// properties
// ----
property p_ser_iface;
    cs && !ser && !non |=> CMD_DONE_O && CMD_ERR_O == `RML_ERR_IFACE;
endproperty
a_ser_iface: assert property (p_ser_iface) else $error("serial clear not refused");
property p_power;
    cs && ser && POWER_FAULT_I |=> CMD_DONE_O && CMD_ERR_O == `RML_ERR_POWER;
endproperty
a_power: assert property (p_power) else $error("supply fault not reported");
property p_mode;
    cs && ser && !POWER_FAULT_I && !POLLED_MODE_I |=> CMD_ERR_O == `RML_ERR_MODE;
endproperty
a_mode: assert property (p_mode) else $error("frame outside polled mode");
// done must not come before the full encoder recovery wait
property p_ser_wait;
    ENC_RESET_REQ_O |-> CMD_BUSY_O ##WD CMD_DONE_O && CMD_ERR_O == `RML_ERR_OK;
endproperty
a_ser_wait: assert property (p_ser_wait) else $error("reset wait wrong");
property p_start_opt;
    tk && CMD_CODE_I == `RML_CMD_START && !non && !ser && (CMD_OPT_I == 2'h0 || CMD_OPT_I == 2'h3)
        |=> CMD_ERR_O == `RML_ERR_PARAM;
endproperty
a_start_opt: assert property (p_start_opt) else $error("bad option taken");
property p_stat_iface;
    tk && CMD_CODE_I == `RML_CMD_CLR_STAT && (AXIS_IF_I == `RML_IF_INCR || ser)
        |=> CMD_ERR_O == `RML_ERR_IFACE;
endproperty
a_stat_iface: assert property (p_stat_iface) else $error("status clear not refused");
property p_capture;
    RUN_ACTIVE_O && REF_PULSE_I && !tk
        |=> REF_POS1_O == $past(PERIOD_CNT_I) || REF_POS2_O == $past(PERIOD_CNT_I);
endproperty
a_capture: assert property (p_capture) else $error("capture value wrong");
property p_rev;
    ENC_POS_REQ_O |-> ENC_REV_O == `RML_REV_OLD && CMD_BUSY_O;
endproperty
a_rev: assert property (p_rev) else $error("newer revision requested");
property p_sticky;
    $fell(STATUS_O[`RML_ST_AMPL]) |-> $past(ack, 2);
endproperty
a_sticky: assert property (p_sticky) else $error("error flag dropped");
c_two: cover property ($fell(RUN_ACTIVE_O) ##1 STATUS_O[1]);
c_wait: cover property (ENC_RESET_REQ_O);
c_restart: cover property (STATUS_O[`RML_ST_REF_INVAL]);
endmodule
bind rml_axis rml_axis_props #(.RESET_WAIT_CYC(RESET_WAIT_CYC)) u_props (
    .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .CMD_VALID_I(CMD_VALID_I),
    .CMD_CODE_I(CMD_CODE_I), .CMD_OPT_I(CMD_OPT_I), .AXIS_IF_I(AXIS_IF_I),
    .POLLED_MODE_I(POLLED_MODE_I), .POWER_FAULT_I(POWER_FAULT_I),
    .PERIOD_CNT_I(PERIOD_CNT_I), .REF_PULSE_I(REF_PULSE_I), .CMD_DONE_O(CMD_DONE_O),
    .CMD_ERR_O(CMD_ERR_O), .CMD_BUSY_O(CMD_BUSY_O), .STATUS_O(STATUS_O),
    .REF_POS1_O(REF_POS1_O), .REF_POS2_O(REF_POS2_O), .RUN_ACTIVE_O(RUN_ACTIVE_O),
    .ENC_RESET_REQ_O(ENC_RESET_REQ_O), .ENC_POS_REQ_O(ENC_POS_REQ_O), .ENC_REV_O(ENC_REV_O));
`default_nettype wire

// ---- testbench/rml_enc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// serial encoder far side
// ----
module rml_enc_model (
    input  wire        clk_i,     // clock
    input  wire        reset_n_i, // reset, low
    input  wire        pos_req_i, // position frame
    input  wire        rst_req_i, // reset frame
    input  wire        rev_i,     // frame revision
    input  wire [7:0]  dly_i,     // answer delay
    output logic       done_o,    // frame end pulse
    output int         pos_cnt_o, // position frames
    output int         old_cnt_o, // old revision frames
    output int         rst_cnt_o  // reset frames
);
int wait_r;
// answers only what was asked; delay lets the bench act slow or prompt
always @(posedge clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        wait_r <= 0;
        done_o <= 1'b0;
        pos_cnt_o <= 0;
        old_cnt_o <= 0;
        rst_cnt_o <= 0;
    end
    else
    begin
        done_o <= wait_r == 1;
        if (wait_r > 0)
            wait_r <= wait_r - 1;
        if (pos_req_i)
        begin
            wait_r <= dly_i + 1;
            pos_cnt_o <= pos_cnt_o + 1;
            old_cnt_o <= old_cnt_o + (rev_i === 1'b0);
        end
        if (rst_req_i)
            rst_cnt_o <= rst_cnt_o + 1;
    end
end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rml_consts.vh"
module testbench;
// ----
// stimulus, outputs, model
// ----
localparam [23:0] WAIT = 24'h000014;
logic        clk = 1'b0;
logic        rst_n = 1'b0;
logic        vld = 1'b0;
logic [3:0]  code = 4'h0;
logic [1:0]  opt = 2'h0;
logic [31:0] lim = 32'h0;
logic [1:0]  axis = 2'h0;
logic        polled = 1'b0;
logic        pfault = 1'b0;
logic [31:0] pcnt = 32'h0;
logic        refp = 1'b0;
logic [5:0]  ev = 6'h00;
logic [7:0]  dly = 8'h03;
wire         fdone, done, busy, run, mon_en, erq, prq, rev;
wire  [2:0]  err;
wire  [9:0]  st;
wire  [31:0] pos1, pos2, mon_lim;
int          pos_n, old_n, rst_cnt;
int          errors = 0;
int          samples_checked = 0;
int          cyc = 0;
logic [9:0]  m_st;
logic [31:0] m_p1, m_p2, m_ml;
logic        m_me;
int          q[$];
rml_axis #(.RESET_WAIT_CYC(WAIT)) DUT (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .CMD_VALID_I(vld), .CMD_CODE_I(code),
    .CMD_OPT_I(opt), .CMD_LIMIT_I(lim), .AXIS_IF_I(axis), .POLLED_MODE_I(polled),
    .POWER_FAULT_I(pfault), .PERIOD_CNT_I(pcnt), .REF_PULSE_I(refp), .ERR_AMPL_I(ev[2]),
    .ERR_FREQ_I(ev[3]), .ERR_CRC_I(ev[4]), .ERR_ENC_MSG_I(ev[5]), .CODED_OK_I(ev[0]),
    .CODED_ERR_I(ev[1]), .ENC_FRAME_DONE_I(fdone), .CMD_DONE_O(done), .CMD_ERR_O(err),
    .CMD_BUSY_O(busy), .STATUS_O(st), .REF_POS1_O(pos1), .REF_POS2_O(pos2),
    .RUN_ACTIVE_O(run), .MON_EN_O(mon_en), .MON_LIMIT_O(mon_lim), .ENC_RESET_REQ_O(erq),
    .ENC_POS_REQ_O(prq), .ENC_REV_O(rev));
rml_enc_model u_enc (.clk_i(clk), .reset_n_i(rst_n), .pos_req_i(prq), .rst_req_i(erq),
    .rev_i(rev), .dly_i(dly), .done_o(fdone), .pos_cnt_o(pos_n), .old_cnt_o(old_n),
    .rst_cnt_o(rst_cnt));
initial forever #10 clk = ~clk;
always @(posedge clk)
begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
        errors++;
        end_of_test;
    end
end
// ----
// tasks
// ----
task automatic end_of_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
        errors++;
        $display("unexpected %s exp %0h got %0h", n, e, g);
    end
endtask
task automatic chk_all;
    chk("status", 32'(m_st), 32'(st));
    chk("pos1", m_p1, pos1);
    chk("pos2", m_p2, pos2);
    chk("run", 32'(m_st[9]), 32'(run));
    chk("mon limit", m_ml, mon_lim);
    chk("mon enable", 32'(m_me), 32'(mon_en));
endtask
function automatic [2:0] xe(input [3:0] c, input [1:0] o);
    xe = `RML_ERR_OK;
    if (c == `RML_CMD_MONITOR)
        xe = (axis == `RML_IF_NONE || axis == `RML_IF_SERIAL) ? `RML_ERR_IFACE :
             o[1] ? `RML_ERR_PARAM : `RML_ERR_OK;
    else if (c == `RML_CMD_QUERY)
        xe = `RML_ERR_OK;
    else if (axis == `RML_IF_NONE)
        xe = `RML_ERR_UNCONF;
    else if (c == `RML_CMD_CLR_SER || c == `RML_CMD_LEGACY)
        xe = axis != `RML_IF_SERIAL ? `RML_ERR_IFACE : pfault ? `RML_ERR_POWER :
             !polled ? `RML_ERR_MODE : `RML_ERR_OK;
    else if (c == `RML_CMD_CLR_STAT && axis != `RML_IF_CODED)
        xe = `RML_ERR_IFACE;
    else if (c != `RML_CMD_ACK_SIG && axis == `RML_IF_SERIAL)
        xe = `RML_ERR_IFACE;
    else if (c == `RML_CMD_START && (o == 2'h0 || o == 2'h3))
        xe = `RML_ERR_PARAM;
endfunction
task automatic reset_dut;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    m_st = 10'h000;
    m_p1 = 32'h0;
    m_p2 = 32'h0;
    m_ml = 32'h0;
    m_me = 1'b0;
    q.delete();
    #1 chk_all;
endtask
// strobe is one cycle wide; latency counted in edges after the taking edge
task automatic go(input [3:0] c, input [1:0] o);
    logic [2:0] x;
    logic [31:0] l;
    int n;
    l = $urandom;
    @(posedge clk);
    x = xe(c, o);
    vld <= 1'b1;
    code <= c;
    opt <= o;
    lim <= l;
    @(posedge clk);
    vld <= 1'b0;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 300)
    begin
        @(posedge clk);
        #1;
        n++;
    end
    chk("err", 32'(x), 32'(err));
    if (c == `RML_CMD_CLR_SER && x == `RML_ERR_OK)
        chk("latency", 32'(WAIT) + 2, 32'(n));
    if (x == `RML_ERR_OK)
        case (c)
        `RML_CMD_ACK_SIG:
            if (axis == `RML_IF_SERIAL)
                m_st[7:6] = 2'h0;
            else
                m_st[5:4] = 2'h0;
        `RML_CMD_CLR_SER: m_st[7:6] = 2'h0;
        `RML_CMD_CLR_LAT: m_st = m_st & 10'h2FC;
        `RML_CMD_CLR_STAT: m_st = m_st & 10'h2F0;
        `RML_CMD_START:
        begin
            if (q.size() > 0)
                m_st = m_st | 10'h100;
            m_st = m_st & 10'h3FC;
            q = (o == `RML_CAP_TWO) ? {1, 2} : {1};
            m_st[9] = 1'b1;
        end
        `RML_CMD_STOP:
        begin
            q.delete();
            m_st[9] = 1'b0;
        end
        `RML_CMD_MONITOR:
        begin
            m_me = o[0];
            m_ml = l;
        end
        default: ;
        endcase
    repeat (2) @(posedge clk);
    #1 chk_all;
endtask
task automatic pulse;
    logic [31:0] v;
    int s;
    v = $urandom;
    @(posedge clk);
    pcnt <= v;
    refp <= 1'b1;
    @(posedge clk);
    pcnt <= $urandom;
    refp <= 1'b0;
    s = q.size() > 0 ? q.pop_front() : 0;
    if (s == 1)
        m_p1 = v;
    if (s == 2)
        m_p2 = v;
    if (s != 0)
        m_st = (m_st | (10'h001 << (s - 1))) & 10'h2FF;
    m_st[9] = q.size() != 0;
    repeat (2) @(posedge clk);
    #1 chk_all;
endtask
task automatic evt(input int b);
    @(posedge clk);
    ev[b - 2] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
    m_st[b] = 1'b1;
    repeat (5) @(posedge clk);
    #1 chk_all;
endtask
// ----
// main sequence
// ----
initial
begin
    logic [3:0] c;
    void'($urandom(45195));
    reset_dut;
    repeat (150)
    begin
        @(posedge clk);
        axis <= 2'($urandom);
        polled <= ($urandom % 4) != 0;
        pfault <= ($urandom % 4) == 0;
        c = 4'(1 + $urandom % 8);
        if (c >= 4'h7)
            c = c + 4'h1;
        go(c, 2'($urandom));
    end
    reset_dut;
    @(posedge clk);
    axis <= `RML_IF_INCR;
    polled <= 1'b1;
    pfault <= 1'b0;
    go(`RML_CMD_START, `RML_CAP_TWO);
    repeat (3) pulse;
    go(`RML_CMD_CLR_LAT, 2'h0);
    go(`RML_CMD_START, `RML_CAP_TWO);
    pulse;
    go(`RML_CMD_START, `RML_CAP_ONE);
    pulse;
    go(`RML_CMD_START, `RML_CAP_TWO);
    pulse;
    go(`RML_CMD_STOP, 2'h0);
    pulse;
    evt(`RML_ST_AMPL);
    evt(`RML_ST_FREQ);
    go(`RML_CMD_ACK_SIG, 2'h0);
    go(`RML_CMD_MONITOR, 2'h1);
    go(`RML_CMD_QUERY, 2'h0);
    @(posedge clk);
    axis <= `RML_IF_CODED;
    evt(`RML_ST_CODED_OK);
    evt(`RML_ST_CODED_ERR);
    go(`RML_CMD_START, `RML_CAP_ONE);
    pulse;
    go(`RML_CMD_CLR_STAT, 2'h0);
    @(posedge clk);
    axis <= `RML_IF_SERIAL;
    evt(`RML_ST_CRC);
    evt(`RML_ST_ENC_MSG);
    go(`RML_CMD_ACK_SIG, 2'h0);
    chk("resets", 32'h0, 32'(rst_cnt));
    evt(`RML_ST_CRC);
    go(`RML_CMD_CLR_SER, 2'h0);
    chk("resets", 32'h1, 32'(rst_cnt));
    go(`RML_CMD_LEGACY, 2'h0);
    @(posedge clk);
    dly <= 8'h28;
    go(`RML_CMD_LEGACY, 2'h0);
    chk("old frames", 32'h2, 32'(old_n));
    chk("frames", 32'h2, 32'(pos_n));
    end_of_test;
end
endmodule
`default_nettype wire
